// file: design/charger_regs_pkg.sv
// constants, field layouts and enumerations of the charger status and
// input-limit register bank; assumes a host on a two-wire serial bus.
//
// Contract
// - input type field bits 7:5, codes 000-011
// - input type codes 100-111: hv, unknown, nonstd, boost
// - current limit reported elsewhere, not in type
// - charge phase bits 4:3: none,pre,fast,done
// - bit 0 set during minimum system regulation
// - fault bit 7 shows watchdog expiry
// - fault bit 6 shows boost mode faults
// - charge fault code bits 5:4
// - limit register bit 7 selects relative/absolute
// - threshold code 7 bits, 2.6V plus 100mV
// - codes below 0001101 act as 3.9V
// - relative mode: code read-only, internally updated
// - absolute mode: host reads and writes code
// - source plug-in restores whole limit register
// - status registers read-only, live device state
// - force optimizer bit: set only, self clears
package charger_regs_pkg;

   localparam logic [7:0] addr_optimizer     = 8'h09;
   localparam logic [7:0] addr_input_status  = 8'h0b;
   localparam logic [7:0] addr_fault_status  = 8'h0c;
   localparam logic [7:0] addr_ilim          = 8'h0d;

   localparam logic [7:0] ilim_reset         = 8'h12;
   localparam logic [6:0] ilim_code_min      = 7'h0d;
   localparam int         ilim_offset_mv     = 2600;
   localparam int         ilim_step_mv       = 100;

   localparam int         ilim_mode_bit      = 7;
   localparam int         optimizer_bit      = 7;

   // bus address, arbitrary value
   localparam logic [6:0] bus_dev_addr       = 7'h50;
   localparam logic [3:0] bits_per_byte      = 4'h8;

   typedef enum logic [2:0] {
      src_none    = 3'h0,
      src_usb_sdp = 3'h1,
      src_usb_cdp = 3'h2,
      src_usb_dcp = 3'h3,
      src_hv_dcp  = 3'h4,
      src_unknown = 3'h5,
      src_nonstd  = 3'h6,
      src_otg     = 3'h7
   } input_source_t;

   typedef enum logic [1:0] {
      phase_idle = 2'h0,
      phase_pre  = 2'h1,
      phase_fast = 2'h2,
      phase_done = 2'h3
   } charge_phase_t;

   typedef enum logic [1:0] {
      cfault_none    = 2'h0,
      cfault_input   = 2'h1,
      cfault_thermal = 2'h2,
      cfault_timer   = 2'h3
   } charge_fault_t;

   typedef enum logic [3:0] {
      bus_idle, bus_addr, bus_ack_addr, bus_ptr, bus_ack_ptr,
      bus_wr, bus_ack_wr, bus_rd, bus_rd_ack
   } bus_state_t;

endpackage

// file: design/charger_reg_bank.sv
// register storage of the charger: two live status registers, the
// input-limit control register and the force-optimizer bit.
// assumes one-cycle write strobes from the serial slave.
`timescale 1ns/1ps
module charger_reg_bank
   import charger_regs_pkg::*;
(
   input  wire logic                            clock,
   input  wire logic                            rst,
   input  wire logic                            wr_en,
   input  wire logic [7:0]                      wr_addr,
   input  wire logic [7:0]                      wr_data,
   input  wire logic [7:0]                      rd_addr,
   input  wire charger_regs_pkg::input_source_t input_source_type,
   input  wire charger_regs_pkg::charge_phase_t charge_phase,
   input  wire logic                            power_good_flag,
   input  wire logic                            min_system_reg_flag,
   input  wire logic                            watchdog_fault,
   input  wire logic                            boost_fault,
   input  wire charger_regs_pkg::charge_fault_t charge_fault_code,
   input  wire logic                            battery_fault,
   input  wire logic [2:0]                      thermistor_fault,
   input  wire logic                            source_plugged,
   input  wire logic                            rel_limit_load,
   input  wire logic [6:0]                      rel_limit_code,
   input  wire logic                            optimizer_started,
   output logic [7:0]                           rd_data,
   output logic                                 abs_input_limit_select,
   output logic [6:0]                           input_volt_limit_code,
   output logic [6:0]                           effective_limit_code,
   output logic                                 force_input_optimizer
);
   import charger_regs_pkg::*;

   logic [7:0] input_and_charge_status;
   logic [7:0] fault_status;
   logic       wr_ilim;
   logic       wr_opt;

   assign wr_ilim = wr_en && (wr_addr == addr_ilim);
   assign wr_opt  = wr_en && (wr_addr == addr_optimizer);

   // live status, no host write path
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         input_and_charge_status <= 8'h00;
         fault_status            <= 8'h00;
      end else begin
         input_and_charge_status <= {input_source_type,
                                     charge_phase,
                                     power_good_flag,
                                     1'b0,
                                     min_system_reg_flag};
         fault_status <= {watchdog_fault,
                          boost_fault,
                          charge_fault_code,
                          battery_fault,
                          thermistor_fault};
      end
   end

   // input-limit control register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         abs_input_limit_select <= ilim_reset[ilim_mode_bit];
         input_volt_limit_code  <= ilim_reset[6:0];
      end else if (source_plugged) begin
         abs_input_limit_select <= ilim_reset[ilim_mode_bit];
         input_volt_limit_code  <= ilim_reset[6:0];
      end else if (wr_ilim) begin
         abs_input_limit_select <= wr_data[ilim_mode_bit];
         if (wr_data[ilim_mode_bit]) begin
            input_volt_limit_code <= wr_data[6:0];
         end else if (rel_limit_load) begin
            input_volt_limit_code <= rel_limit_code;
         end
      end else if (!abs_input_limit_select && rel_limit_load) begin
         input_volt_limit_code <= rel_limit_code;
      end
   end

   // threshold used by the regulator
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         effective_limit_code <= ilim_reset[6:0];
      end else if (input_volt_limit_code < ilim_code_min) begin
         effective_limit_code <= ilim_code_min;
      end else begin
         effective_limit_code <= input_volt_limit_code;
      end
   end

   // set wins over the self clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         force_input_optimizer <= 1'b0;
      end else if (wr_opt && wr_data[optimizer_bit]) begin
         force_input_optimizer <= 1'b1;
      end else if (optimizer_started) begin
         force_input_optimizer <= 1'b0;
      end
   end

   // read mux, unmapped reads as zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else begin
         unique case (rd_addr)
            addr_input_status: rd_data <= input_and_charge_status;
            addr_fault_status: rd_data <= fault_status;
            addr_ilim:         rd_data <= {abs_input_limit_select,
                                           input_volt_limit_code};
            addr_optimizer:    rd_data <= {force_input_optimizer, 7'h00};
            default:           rd_data <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_plug_restores: assert property (
      source_plugged |=> {abs_input_limit_select, input_volt_limit_code}
                         == 8'h12)
      else $error("limit register not restored on plug-in");
   a_rel_update: assert property (
      !source_plugged && !abs_input_limit_select && !wr_ilim
      && rel_limit_load |=> input_volt_limit_code == $past(rel_limit_code))
      else $error("relative threshold not loaded");
   a_rel_write_blocked: assert property (
      !source_plugged && wr_ilim && !wr_data[7] && !rel_limit_load
      |=> $stable(input_volt_limit_code) && !abs_input_limit_select)
      else $error("host changed code in relative mode");
   a_abs_write: assert property (
      !source_plugged && wr_ilim && wr_data[7]
      |=> {abs_input_limit_select, input_volt_limit_code}
          == $past(wr_data))
      else $error("absolute write not stored");
   a_clamp_min: assert property (
      ##1 effective_limit_code >= 7'h0d && (
      $past(input_volt_limit_code) < 7'h0d
      || effective_limit_code == $past(input_volt_limit_code)))
      else $error("threshold clamp wrong");
   a_force_clears: assert property (
      optimizer_started && !(wr_opt && wr_data[7])
      |=> !force_input_optimizer)
      else $error("force bit did not self clear");
   a_force_zero_ignored: assert property (
      !force_input_optimizer && !(wr_opt && wr_data[7])
      |=> !force_input_optimizer)
      else $error("force bit set without a one write");
   a_status_live: assert property (
      ##1 rd_addr == 8'h0b && $stable(rd_addr) |=> rd_data ==
      {$past(input_source_type, 2), $past(charge_phase, 2),
       $past(power_good_flag, 2), 1'b0, $past(min_system_reg_flag, 2)})
      else $error("status register not live");
   a_fault_live: assert property (
      rd_addr == 8'h0c ##1 rd_addr == 8'h0c |=>
      rd_data[7:4] == {$past(watchdog_fault, 2), $past(boost_fault, 2),
                       $past(charge_fault_code, 2)})
      else $error("fault register not live");

   c_plug: cover property (source_plugged ##1 !source_plugged);
   c_abs_write: cover property (wr_ilim && wr_data[7]);
   c_force: cover property (force_input_optimizer ##1
                            !force_input_optimizer);
endmodule

// file: design/charger_status_and_input_limit_regs.sv
// two-wire serial slave in front of the charger register bank.
// assumes scl and sda are synchronous to clock and slow against it;
// sda is open drain: the testbench resolves the wire from sda_oe.
`timescale 1ns/1ps
module charger_status_and_input_limit_regs
   import charger_regs_pkg::*;
(
   input  wire logic                            clock,
   input  wire logic                            rst,
   input  wire logic                            scl,
   input  wire logic                            sda_in,
   output logic                                 sda_out,
   output logic                                 sda_oe,
   input  wire charger_regs_pkg::input_source_t input_source_type,
   input  wire charger_regs_pkg::charge_phase_t charge_phase,
   input  wire logic                            power_good_flag,
   input  wire logic                            min_system_reg_flag,
   input  wire logic                            watchdog_fault,
   input  wire logic                            boost_fault,
   input  wire charger_regs_pkg::charge_fault_t charge_fault_code,
   input  wire logic                            battery_fault,
   input  wire logic [2:0]                      thermistor_fault,
   input  wire logic                            source_plugged,
   input  wire logic                            rel_limit_load,
   input  wire logic [6:0]                      rel_limit_code,
   input  wire logic                            optimizer_started,
   output logic                                 abs_input_limit_select,
   output logic [6:0]                           input_volt_limit_code,
   output logic [6:0]                           effective_limit_code,
   output logic                                 force_input_optimizer
);
   import charger_regs_pkg::*;

   bus_state_t state;
   logic       scl_q;
   logic       sda_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] tx;
   logic [7:0] ptr;
   logic       read_dir;
   logic       wr_en;
   logic [7:0] wr_data;
   logic [7:0] rd_data;

   assign scl_rise   = scl && !scl_q;
   assign scl_fall   = !scl && scl_q;
   assign start_seen = scl && scl_q && sda_q && !sda_in;
   assign stop_seen  = scl && scl_q && !sda_q && sda_in;

   // line history for edge and condition detection
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   // open drain: only ever pulls low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // bit sampling on scl rise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shift   <= 8'h00;
         bit_cnt <= 4'h0;
      end else if (start_seen) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise && (state == bus_addr || state == bus_ptr
                                || state == bus_wr || state == bus_rd)) begin
         shift   <= {shift[6:0], sda_in};
         bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall && (state == bus_ack_addr
                   || state == bus_ack_ptr || state == bus_ack_wr
                   || state == bus_rd_ack)) begin
         bit_cnt <= 4'h0;
      end
   end

   // transfer sequencing, driving sda after each scl fall
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state    <= bus_idle;
         sda_oe   <= 1'b0;
         read_dir <= 1'b0;
         ptr      <= 8'h00;
         tx       <= 8'h00;
         wr_en    <= 1'b0;
         wr_data  <= 8'h00;
      end else begin
         wr_en <= 1'b0;
         if (start_seen) begin
            state  <= bus_addr;
            sda_oe <= 1'b0;
         end else if (stop_seen) begin
            state  <= bus_idle;
            sda_oe <= 1'b0;
         end else if (scl_rise && state == bus_rd_ack && sda_in) begin
            state <= bus_idle;
         end else if (scl_fall) begin
            unique case (state)
               bus_idle: begin
                  sda_oe <= 1'b0;
               end
               bus_addr: begin
                  if (bit_cnt == bits_per_byte) begin
                     if (shift[7:1] == bus_dev_addr) begin
                        read_dir <= shift[0];
                        sda_oe   <= 1'b1;
                        state    <= bus_ack_addr;
                     end else begin
                        state <= bus_idle;
                     end
                  end
               end
               bus_ack_addr: begin
                  if (read_dir) begin
                     tx     <= {rd_data[6:0], 1'b0};
                     sda_oe <= !rd_data[7];
                     state  <= bus_rd;
                  end else begin
                     sda_oe <= 1'b0;
                     state  <= bus_ptr;
                  end
               end
               bus_ptr: begin
                  if (bit_cnt == bits_per_byte) begin
                     ptr    <= shift;
                     sda_oe <= 1'b1;
                     state  <= bus_ack_ptr;
                  end
               end
               bus_ack_ptr: begin
                  sda_oe <= 1'b0;
                  state  <= bus_wr;
               end
               bus_wr: begin
                  if (bit_cnt == bits_per_byte) begin
                     wr_en   <= 1'b1;
                     wr_data <= shift;
                     sda_oe  <= 1'b1;
                     state   <= bus_ack_wr;
                  end
               end
               bus_ack_wr: begin
                  ptr    <= ptr + 8'h01;
                  sda_oe <= 1'b0;
                  state  <= bus_wr;
               end
               bus_rd: begin
                  if (bit_cnt == bits_per_byte) begin
                     ptr    <= ptr + 8'h01;
                     sda_oe <= 1'b0;
                     state  <= bus_rd_ack;
                  end else begin
                     sda_oe <= !tx[7];
                     tx     <= {tx[6:0], 1'b0};
                  end
               end
               bus_rd_ack: begin
                  tx     <= {rd_data[6:0], 1'b0};
                  sda_oe <= !rd_data[7];
                  state  <= bus_rd;
               end
               default: begin
                  state <= bus_idle;
               end
            endcase
         end
      end
   end

   charger_reg_bank u_bank (
      .clock                  (clock),
      .rst                    (rst),
      .wr_en                  (wr_en),
      .wr_addr                (ptr),
      .wr_data                (wr_data),
      .rd_addr                (ptr),
      .input_source_type      (input_source_type),
      .charge_phase           (charge_phase),
      .power_good_flag        (power_good_flag),
      .min_system_reg_flag    (min_system_reg_flag),
      .watchdog_fault         (watchdog_fault),
      .boost_fault            (boost_fault),
      .charge_fault_code      (charge_fault_code),
      .battery_fault          (battery_fault),
      .thermistor_fault       (thermistor_fault),
      .source_plugged         (source_plugged),
      .rel_limit_load         (rel_limit_load),
      .rel_limit_code         (rel_limit_code),
      .optimizer_started      (optimizer_started),
      .rd_data                (rd_data),
      .abs_input_limit_select (abs_input_limit_select),
      .input_volt_limit_code  (input_volt_limit_code),
      .effective_limit_code   (effective_limit_code),
      .force_input_optimizer  (force_input_optimizer)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_ack_driven: assert property (
      state == bus_ack_addr || state == bus_ack_ptr
      || state == bus_ack_wr |-> sda_oe)
      else $error("ack not driven low");
   a_stop_idles: assert property (
      stop_seen |=> state == bus_idle && !sda_oe)
      else $error("stop did not release the bus");
   a_write_pulse: assert property (
      wr_en |-> state == bus_ack_wr && sda_oe ##1 !wr_en)
      else $error("write strobe not a single pulse at data ack");

   c_read: cover property (state == bus_rd && ptr == 8'h0b);
   c_write: cover property (wr_en && ptr == 8'h0d);
endmodule

// file: verif/serial_host.sv
// host model: bus master of the two-wire serial register bus.
// assumes a pull-up on sda; the bench resolves the wire.
`timescale 1ns/1ps
module serial_host
   import charger_regs_pkg::*;
(
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe
);
   import charger_regs_pkg::*;
   logic ack_ok;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
      ack_ok = 1'b1;
   end
   task automatic hold();
      repeat (5) @(negedge clock);
   endtask
   task automatic start();
      @(negedge clock);
      sda_oe = 1'b0;
      hold();
      scl = 1'b1;
      hold();
      sda_oe = 1'b1;
      hold();
      scl = 1'b0;
   endtask
   task automatic stop();
      hold();
      sda_oe = 1'b1;
      hold();
      scl = 1'b1;
      hold();
      sda_oe = 1'b0;
      hold();
   endtask
   task automatic put_bit(input logic b);
      @(negedge clock);
      sda_oe = ~b;
      hold();
      scl = 1'b1;
      hold();
      scl = 1'b0;
   endtask
   task automatic get_bit(output logic b);
      @(negedge clock);
      sda_oe = 1'b0;
      hold();
      scl = 1'b1;
      repeat (3) @(negedge clock);
      b = sda;
      repeat (2) @(negedge clock);
      scl = 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(a);
      ack_ok = ack_ok & ~a;
   endtask
   // mode bit and code travel in one data byte
   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
      ack_ok = 1'b1;
      start();
      put_byte({bus_dev_addr, 1'b0});
      put_byte(ptr);
      put_byte(d);
      stop();
   endtask
   // address-only frame, leaves ack_ok low when nobody answers
   task automatic probe(input logic [6:0] dev);
      ack_ok = 1'b1;
      start();
      put_byte({dev, 1'b0});
      stop();
   endtask
   // two-byte read: host acks the first byte, nacks the second
   task automatic read_pair(input logic [7:0] ptr, output logic [15:0] d);
      ack_ok = 1'b1;
      start();
      put_byte({bus_dev_addr, 1'b0});
      put_byte(ptr);
      start();
      put_byte({bus_dev_addr, 1'b1});
      for (int i = 15; i >= 8; i--) get_bit(d[i]);
      put_bit(1'b0);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(1'b1);
      stop();
   endtask
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
      ack_ok = 1'b1;
      start();
      put_byte({bus_dev_addr, 1'b0});
      put_byte(ptr);
      start();
      put_byte({bus_dev_addr, 1'b1});
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(1'b1);
      stop();
   endtask
endmodule

// file: verif/testbench.sv
// bench for the charger register bank behind its serial slave.
// assumes the host model drives the bus; sda is pulled up.
`timescale 1ns/1ps
module testbench;
   import charger_regs_pkg::*;
   logic          clock, rst, scl, host_oe, sda_oe, sda_out, sda;
   input_source_t src;
   charge_phase_t phase;
   charge_fault_t cfault;
   logic          pg, minsys, wd, bf, batf, plug, rload, ostart;
   logic [2:0]    therm;
   logic [6:0]    rcode, code, eff;
   logic          abs_sel, force_opt;
   logic [7:0]    rd;
   logic [15:0]   pair;
   logic [6:0]    vals [4] = '{7'h00, 7'h0c, 7'h0d, 7'h7f};
   int            failures, checked, cycles;
   assign sda = ~(host_oe | sda_oe);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   charger_status_and_input_limit_regs DUT (
      .clock(clock), .rst(rst), .scl(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .input_source_type(src),
      .charge_phase(phase), .power_good_flag(pg),
      .min_system_reg_flag(minsys), .watchdog_fault(wd),
      .boost_fault(bf), .charge_fault_code(cfault),
      .battery_fault(batf), .thermistor_fault(therm),
      .source_plugged(plug), .rel_limit_load(rload),
      .rel_limit_code(rcode), .optimizer_started(ostart),
      .abs_input_limit_select(abs_sel), .input_volt_limit_code(code),
      .effective_limit_code(eff), .force_input_optimizer(force_opt)
   );
   serial_host host (
      .clock(clock), .sda(sda), .scl(scl), .sda_oe(host_oe)
   );
   task automatic check(input string what, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ptr, exp, input string what);
      host.read_reg(ptr, rd);
      check(what, rd, exp);
   endtask
   task automatic settle();
      repeat (2) @(negedge clock);
   endtask
   task automatic results();
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         failures++;
         results();
      end
   end
   initial begin
      {rst, pg, minsys, wd, bf, batf, plug, rload, ostart} = 9'h100;
      src = src_none;
      phase = phase_idle;
      cfault = cfault_none;
      therm = 3'h0;
      rcode = 7'h00;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      settle();
      check("select", {7'h00, abs_sel}, 8'h00);
      check("code", {1'b0, code}, 8'h12);
      check("force", {7'h00, force_opt}, 8'h00);
      rd_chk(addr_ilim, 8'h12, "limit");
      for (int i = 0; i < 8; i++) begin
         src = input_source_t'(i[2:0]);
         phase = charge_phase_t'(i[1:0]);
         pg = i[0];
         minsys = i[1];
         rd_chk(addr_input_status, {i[2:0], i[1:0], i[0], 1'b0, i[1]},
            "status");
      end
      host.write_reg(addr_input_status, 8'h00);
      check("ack", {7'h00, host.ack_ok}, 8'h01);
      check("sda out", {7'h00, sda_out}, 8'h00);
      host.probe(~bus_dev_addr);
      check("nack", {7'h00, host.ack_ok}, 8'h00);
      rd_chk(addr_input_status, 8'hfd, "status ro");
      for (int i = 0; i < 4; i++) begin
         wd = i[0];
         bf = i[1];
         cfault = charge_fault_t'(i[1:0]);
         batf = i[0];
         therm = {i[1:0], ~i[0]};
         rd_chk(addr_fault_status,
            {i[0], i[1], i[1:0], i[0], i[1:0], ~i[0]},
            "fault");
      end
      host.write_reg(addr_ilim, 8'h33);
      rd_chk(addr_ilim, 8'h12, "relative ro");
      rcode = 7'h20;
      rload = 1'b1;
      @(negedge clock);
      rload = 1'b0;
      settle();
      rd_chk(addr_ilim, 8'h20, "relative load");
      foreach (vals[k]) begin
         host.write_reg(addr_ilim, {1'b1, vals[k]});
         settle();
         check("effective", {1'b0, eff},
            {1'b0, (vals[k] < 7'h0d) ? 7'h0d : vals[k]});
      end
      check("select", {7'h00, abs_sel}, 8'h01);
      rd_chk(addr_ilim, 8'hff, "absolute rw");
      rload = 1'b1;
      @(negedge clock);
      rload = 1'b0;
      settle();
      check("code", {1'b0, code}, 8'h7f);
      plug = 1'b1;
      @(negedge clock);
      plug = 1'b0;
      settle();
      check("select", {7'h00, abs_sel}, 8'h00);
      rd_chk(addr_ilim, 8'h12, "plug");
      host.read_pair(addr_fault_status, pair);
      check("burst fault", pair[15:8], 8'hfe);
      check("burst limit", pair[7:0], 8'h12);
      host.write_reg(addr_optimizer, 8'h80);
      settle();
      check("force", {7'h00, force_opt}, 8'h01);
      host.write_reg(addr_optimizer, 8'h00);
      rd_chk(addr_optimizer, 8'h80, "force");
      ostart = 1'b1;
      @(negedge clock);
      ostart = 1'b0;
      settle();
      check("force", {7'h00, force_opt}, 8'h00);
      results();
   end
endmodule
